//--- hdl/eap_regs.v
// Status, ninth-bit and data buffer registers of the async serial port
`include "eap_map.vh"
`default_nettype none

// Functional notes
// - Receive ninth bit loads with the data byte: bit 8 in nine-bit mode, else bit 7.
// - Transmit ninth bit travels with the data byte into the shifter; reset clears it.
// - Four enables gate overrun, noise, framing, parity error requests; reset clears them.
// - Tx-empty sets on handoff to shifter; clears by status read then data write.
// - Tx-done is tx-empty with nothing sending or queued; interrupts when enabled.
// - Queued words reach the shifter well within 1.5 transmitter clocks.
// - Rx-full sets on receive transfer; clears by status read then data read.
// - Idle sets on quiet line detection; interrupts with line-quiet enable.
// - Idle stays clear after enable or clearing until a valid character arrives.
// - Character completing while rx-full set raises overrun and is discarded.
// - Data read clears only flags seen set at the last status read.
// - Noise flag sets on detected noise; cleared by status-then-data read.
// - Framing flag sets on zero stop bit; cleared by status-then-data read.
// - Parity flag sets on failed parity; cleared by status-then-data read.
// - Break sets break, framing and rx-full, clears ninth bit in nine-bit mode only; no interrupt.
// - Break clears by secondary status read then data read; rearms after ones.
// - Rx-active sets on start slot zero; clears on false start or idle.
// - Reset leaves data buffer and receive ninth bit unchanged.
// - Character-length bit selects nine-bit or eight-bit characters.
// - Port disable forces tx-empty and tx-done set, blocks transmit interrupt.
module eap_regs (
	input wire clk_sys,
	input wire rst_n,
	input wire [7:0] bus_addr,
	input wire [7:0] bus_wdata,
	input wire bus_wr,
	input wire bus_rd,
	output reg [7:0] bus_rdata,
	output reg tx_space_ok,
	input wire port_enable,
	input wire char_nine_bits,
	input wire rx_enable,
	input wire tx_empty_irq_enable,
	input wire tx_finished_irq_enable,
	input wire rx_full_irq_enable,
	input wire line_quiet_irq_enable,
	input wire rx_char_valid,
	input wire [8:0] rx_char_data,
	input wire rx_char_noise,
	input wire rx_char_frame_err,
	input wire rx_char_parity_err,
	input wire rx_break,
	input wire rx_line_quiet,
	input wire rx_line_one,
	input wire rx_start_zero,
	input wire rx_false_start,
	output reg tx_valid,
	output reg [8:0] tx_data,
	input wire tx_ready,
	input wire tx_busy,
	input wire tx_queued,
	output reg irq_tx,
	output reg irq_rx,
	output reg irq_err
);

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	wire sel_ctl;
	wire sel_pri;
	wire sel_sec;
	wire sel_dat;
	wire rd_pri;
	wire rd_sec;
	wire rd_dat;
	wire wr_dat;

	assign sel_ctl = (bus_addr == `EAP_OFS_NINTH_ERR);
	assign sel_pri = (bus_addr == `EAP_OFS_STAT_PRI);
	assign sel_sec = (bus_addr == `EAP_OFS_STAT_SEC);
	assign sel_dat = (bus_addr == `EAP_OFS_DATA);
	assign rd_pri = bus_rd & sel_pri;
	assign rd_sec = bus_rd & sel_sec;
	assign rd_dat = bus_rd & sel_dat;
	assign wr_dat = bus_wr & sel_dat;

	// ----------------------------------------
	// State
	// ----------------------------------------
	reg tx_ninth_reg;
	reg [3:0] err_ie_reg;
	reg [7:0] rx_byte_reg;
	reg rx_ninth_reg;
	reg tx_empty_reg;
	reg tx_done_reg;
	reg rx_full_reg;
	reg idle_reg;
	reg ovr_reg;
	reg noise_reg;
	reg frame_reg;
	reg par_reg;
	reg brk_reg;
	reg rx_act_reg;
	reg idle_ok_reg;
	reg brk_lock_reg;
	reg rx_en_d_reg;
	reg [6:0] arm_pri_reg;
	reg arm_brk_reg;

	wire buf_in_ready;
	wire buf_out_valid;
	wire [8:0] buf_out_data;
	wire handoff;
	wire take_char;
	wire load_char;
	wire clr_dat;
	wire brk_take;

	// ----------------------------------------
	// Transmit path through the two-entry buffer
	// ----------------------------------------
	// Holding a second word lets the CPU refill while the shifter is still busy
	eap_pair_buf #(
		.WIDTH(9)
	) u_tx_buf (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.in_valid(wr_dat),
		.in_data({tx_ninth_reg, bus_wdata}),
		.in_ready(buf_in_ready),
		.out_valid(buf_out_valid),
		.out_data(buf_out_data),
		.out_ready(tx_ready)
	);

	assign handoff = buf_out_valid & tx_ready;

	// Copies of the buffer head keep every top output on a flop of this module
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_valid <= 1'b0;
			tx_data <= 9'h000;
			tx_space_ok <= 1'b1;
		end else begin
			tx_valid <= buf_out_valid;
			tx_data <= buf_out_data;
			tx_space_ok <= buf_in_ready;
		end
	end

	// ----------------------------------------
	// Control register writes
	// ----------------------------------------
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_ninth_reg <= 1'b0;
			err_ie_reg <= 4'h0;
		end else if (bus_wr & sel_ctl) begin
			tx_ninth_reg <= bus_wdata[`EAP_NE_TX_NINTH];
			err_ie_reg <= bus_wdata[3:0];
		end
	end

	// ----------------------------------------
	// Receive data, untouched by reset
	// ----------------------------------------
	assign take_char = rx_char_valid | rx_break;
	assign load_char = take_char & ~rx_full_reg;
	assign brk_take = rx_break & ~brk_lock_reg;

	always @(posedge clk_sys) begin
		if (load_char) begin
			if (rx_break) begin
				rx_byte_reg <= 8'h00;
				if (char_nine_bits) begin
					rx_ninth_reg <= 1'b0;
				end
			end else begin
				rx_byte_reg <= rx_char_data[7:0];
				rx_ninth_reg <= char_nine_bits ? rx_char_data[8] : rx_char_data[7];
			end
		end
	end

	// ----------------------------------------
	// Two-step clearing: arm on status read, act on data access
	// ----------------------------------------
	// Flags raised after the status read are not armed and so survive
	assign clr_dat = rd_dat;

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			arm_pri_reg <= 7'h00;
			arm_brk_reg <= 1'b0;
		end else begin
			if (rd_pri) begin
				arm_pri_reg <= {tx_empty_reg, rx_full_reg, idle_reg, ovr_reg,
					noise_reg, frame_reg, par_reg};
			end else begin
				if (clr_dat) begin
					arm_pri_reg[5:0] <= 6'h00;
				end
				if (wr_dat) begin
					arm_pri_reg[6] <= 1'b0;
				end
			end
			if (rd_sec) begin
				arm_brk_reg <= brk_reg;
			end else if (clr_dat) begin
				arm_brk_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Status flags; a set in the clearing cycle wins
	// ----------------------------------------
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_empty_reg <= `EAP_RST_TX_EMPTY;
			rx_full_reg <= `EAP_RST_FLAG;
			idle_reg <= `EAP_RST_FLAG;
			ovr_reg <= `EAP_RST_FLAG;
			noise_reg <= `EAP_RST_FLAG;
			frame_reg <= `EAP_RST_FLAG;
			par_reg <= `EAP_RST_FLAG;
			brk_reg <= `EAP_RST_FLAG;
			rx_act_reg <= `EAP_RST_FLAG;
		end else begin
			if (!port_enable | handoff) begin
				tx_empty_reg <= 1'b1;
			end else if (wr_dat & arm_pri_reg[6]) begin
				tx_empty_reg <= 1'b0;
			end
			if (load_char) begin
				rx_full_reg <= 1'b1;
			end else if (clr_dat & arm_pri_reg[5]) begin
				rx_full_reg <= 1'b0;
			end
			if (rx_line_quiet & idle_ok_reg) begin
				idle_reg <= 1'b1;
			end else if (clr_dat & arm_pri_reg[4]) begin
				idle_reg <= 1'b0;
			end
			if (take_char & rx_full_reg) begin
				ovr_reg <= 1'b1;
			end else if (clr_dat & arm_pri_reg[3]) begin
				ovr_reg <= 1'b0;
			end
			if (rx_char_valid & rx_char_noise) begin
				noise_reg <= 1'b1;
			end else if (clr_dat & arm_pri_reg[2]) begin
				noise_reg <= 1'b0;
			end
			if ((rx_char_valid & rx_char_frame_err) | rx_break) begin
				frame_reg <= 1'b1;
			end else if (clr_dat & arm_pri_reg[1]) begin
				frame_reg <= 1'b0;
			end
			if (rx_char_valid & rx_char_parity_err) begin
				par_reg <= 1'b1;
			end else if (clr_dat & arm_pri_reg[0]) begin
				par_reg <= 1'b0;
			end
			if (brk_take) begin
				brk_reg <= 1'b1;
			end else if (clr_dat & arm_brk_reg) begin
				brk_reg <= 1'b0;
			end
			if (rx_start_zero) begin
				rx_act_reg <= 1'b1;
			end else if (rx_false_start | rx_line_quiet) begin
				rx_act_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Idle qualification and break re-arming
	// ----------------------------------------
	// Without a lock a long low line would re-report the same break
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			idle_ok_reg <= 1'b0;
			brk_lock_reg <= 1'b0;
			rx_en_d_reg <= 1'b0;
		end else begin
			rx_en_d_reg <= rx_enable;
			if (rx_char_valid & ~rx_full_reg) begin
				idle_ok_reg <= 1'b1;
			end else if ((rx_enable & ~rx_en_d_reg) | (rx_line_quiet & idle_ok_reg)) begin
				idle_ok_reg <= 1'b0;
			end
			if (brk_take) begin
				brk_lock_reg <= 1'b1;
			end else if (rx_line_one) begin
				brk_lock_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Transmission complete
	// ----------------------------------------
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_done_reg <= `EAP_RST_TX_DONE;
		end else if (!port_enable) begin
			tx_done_reg <= 1'b1;
		end else begin
			tx_done_reg <= tx_empty_reg & ~buf_out_valid & ~tx_busy & ~tx_queued & ~wr_dat;
		end
	end

	// ----------------------------------------
	// Interrupt requests
	// ----------------------------------------
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq_tx <= 1'b0;
			irq_rx <= 1'b0;
			irq_err <= 1'b0;
		end else begin
			irq_tx <= port_enable & ((tx_empty_reg & tx_empty_irq_enable) |
				(tx_done_reg & tx_finished_irq_enable));
			irq_rx <= (rx_full_reg & rx_full_irq_enable) |
				(idle_reg & line_quiet_irq_enable);
			irq_err <= (ovr_reg & err_ie_reg[`EAP_NE_OVR_IE]) |
				(noise_reg & err_ie_reg[`EAP_NE_NOISE_IE]) |
				(frame_reg & err_ie_reg[`EAP_NE_FRAME_IE]) |
				(par_reg & err_ie_reg[`EAP_NE_PAR_IE]);
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	// Reads and writes of the data offset reach different storage
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			bus_rdata <= `EAP_RST_BYTE;
		end else if (bus_rd) begin
			if (sel_ctl) begin
				bus_rdata <= {rx_ninth_reg, tx_ninth_reg, 2'b00, err_ie_reg};
			end else if (sel_pri) begin
				bus_rdata <= {tx_empty_reg, tx_done_reg, rx_full_reg, idle_reg,
					ovr_reg, noise_reg, frame_reg, par_reg};
			end else if (sel_sec) begin
				bus_rdata <= {6'h00, brk_reg, rx_act_reg};
			end else if (sel_dat) begin
				bus_rdata <= rx_byte_reg;
			end else begin
				bus_rdata <= `EAP_RST_BYTE;
			end
		end else begin
			bus_rdata <= `EAP_RST_BYTE;
		end
	end

endmodule // eap_regs

`default_nettype wire

//--- hdl/eap_map.vh
// Register offsets, field positions and reset values of the async port register block
`ifndef EAP_MAP_VH
`define EAP_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define EAP_OFS_NINTH_ERR 8'h15
`define EAP_OFS_STAT_PRI 8'h16
`define EAP_OFS_STAT_SEC 8'h17
`define EAP_OFS_DATA 8'h18

// ----------------------------------------
// ninth_bit_and_error_enable fields
// ----------------------------------------
`define EAP_NE_RX_NINTH 7
`define EAP_NE_TX_NINTH 6
`define EAP_NE_OVR_IE 3
`define EAP_NE_NOISE_IE 2
`define EAP_NE_FRAME_IE 1
`define EAP_NE_PAR_IE 0
`define EAP_NE_WR_MASK 8'h4F

// ----------------------------------------
// serial_status_primary fields
// ----------------------------------------
`define EAP_SP_TX_EMPTY 7
`define EAP_SP_TX_DONE 6
`define EAP_SP_RX_FULL 5
`define EAP_SP_IDLE 4
`define EAP_SP_OVERRUN 3
`define EAP_SP_NOISE 2
`define EAP_SP_FRAME 1
`define EAP_SP_PARITY 0

// ----------------------------------------
// serial_status_secondary fields
// ----------------------------------------
`define EAP_SS_BREAK 1
`define EAP_SS_RX_ACTIVE 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define EAP_RST_TX_EMPTY 1'b1
`define EAP_RST_TX_DONE 1'b1
`define EAP_RST_FLAG 1'b0
`define EAP_RST_BYTE 8'h00

`endif

//--- hdl/eap_pair_buf.v
// Two-entry buffer with valid/ready on both sides and registered outputs
`default_nettype none

module eap_pair_buf #(
	parameter WIDTH = 9
) (
	input wire clk_sys,
	input wire rst_n,
	input wire in_valid,
	input wire [WIDTH-1:0] in_data,
	output reg in_ready,
	output reg out_valid,
	output reg [WIDTH-1:0] out_data,
	input wire out_ready
);

	// ----------------------------------------
	// Storage: head is the output register, tail is the spare slot
	// ----------------------------------------
	reg tail_valid_reg;
	reg [WIDTH-1:0] tail_data_reg;
	wire push;
	wire pop;

	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// Head is always the output flop so a consumer sees no mux delay
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			out_valid <= 1'b0;
			out_data <= {WIDTH{1'b0}};
			tail_valid_reg <= 1'b0;
			tail_data_reg <= {WIDTH{1'b0}};
			in_ready <= 1'b1;
		end else begin
			if (pop) begin
				if (tail_valid_reg) begin
					out_data <= tail_data_reg;
					tail_valid_reg <= push;
					in_ready <= ~push;
					if (push) begin
						tail_data_reg <= in_data;
					end
				end else begin
					out_valid <= push;
					if (push) begin
						out_data <= in_data;
					end
				end
			end else if (push) begin
				if (out_valid) begin
					tail_valid_reg <= 1'b1;
					tail_data_reg <= in_data;
					in_ready <= 1'b0;
				end else begin
					out_valid <= 1'b1;
					out_data <= in_data;
				end
			end
		end
	end

endmodule // eap_pair_buf

`default_nettype wire

//--- testbench/eap_tx_partner.sv
// Transmit shifter model on the far side of the port's word handshake
`default_nettype none
module eap_tx_partner (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic hold,
	input wire logic tx_valid,
	input wire logic [8:0] tx_data,
	output logic tx_ready,
	output logic tx_busy,
	output logic took,
	output logic [8:0] took_word
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] cnt;
	// ----------------------------------------
	// Accept and shift
	// ----------------------------------------
	// The busy gap keeps a stale tx_valid copy from being taken twice
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_ready <= 1'b0;
			tx_busy <= 1'b0;
			took <= 1'b0;
			took_word <= 9'h000;
			cnt <= 4'h0;
		end else begin
			tx_ready <= tx_valid && !tx_ready && !hold && cnt == 4'h0;
			took <= tx_ready;
			if (tx_ready) begin
				took_word <= tx_data;
				cnt <= 4'h6;
				tx_busy <= 1'b1;
			end else if (cnt != 4'h0) begin
				cnt <= cnt - 4'h1;
				tx_busy <= cnt > 4'h1;
			end
		end
	end
endmodule // eap_tx_partner
`default_nettype wire

//--- testbench/eap_regs_chk.sv
// Port-level assertions for the async port register block
`default_nettype none
module eap_regs_chk (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [7:0] bus_addr,
	input wire logic bus_rd,
	input wire logic [7:0] bus_rdata,
	input wire logic port_enable,
	input wire logic rx_full_irq_enable,
	input wire logic line_quiet_irq_enable,
	input wire logic rx_char_valid,
	input wire logic tx_valid,
	input wire logic [8:0] tx_data,
	input wire logic tx_ready,
	input wire logic irq_tx,
	input wire logic irq_rx
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	rdata_idle_a: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
		else $error("read data not zero between reads");
	unmapped_rd_a: assert property ($past(bus_rd) &&
		($past(bus_addr) < 8'h15 || $past(bus_addr) > 8'h18) |-> bus_rdata == 8'h00)
		else $error("unmapped read not zero");
	ctl_rsvd_a: assert property ($past(bus_rd) && $past(bus_addr) == 8'h15
		|-> bus_rdata[5:4] == 2'b00) else $error("control spare bits set");
	sec_rsvd_a: assert property ($past(bus_rd) && $past(bus_addr) == 8'h17
		|-> bus_rdata[7:2] == 6'h00) else $error("secondary spare bits set");
	off_flags_a: assert property ($past(bus_rd) && $past(bus_addr) == 8'h16 &&
		!$past(port_enable) && !$past(port_enable, 2) |-> bus_rdata[7:6] == 2'b11)
		else $error("disabled port tx flags not set");
	tx_off_irq_a: assert property (!port_enable && !$past(port_enable) |-> !irq_tx)
		else $error("tx irq while port disabled");
	rx_irq_off_a: assert property (!rx_full_irq_enable && !line_quiet_irq_enable &&
		!$past(rx_full_irq_enable) && !$past(line_quiet_irq_enable) |-> !irq_rx)
		else $error("rx irq with enables clear");
	rx_full_irq_a: assert property (rx_char_valid && rx_full_irq_enable && !bus_rd
		##1 rx_full_irq_enable && !bus_rd |=> irq_rx) else $error("no rx irq");
	tx_hold_a: assert property (tx_valid && !tx_ready && !$past(tx_ready) && port_enable
		|=> tx_valid && $stable(tx_data)) else $error("tx word changed unaccepted");
endmodule // eap_regs_chk
bind eap_regs eap_regs_chk chk_i (.*);
`default_nettype wire

//--- testbench/test_eap_regs.sv
// Self-checking bench for the async port register block
`default_nettype none
module test_eap_regs;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] bus_addr = 8'h00;
	logic [7:0] bus_wdata = 8'h00;
	logic bus_wr = 1'b0;
	logic bus_rd = 1'b0;
	logic port_enable = 1'b1;
	logic char_nine_bits = 1'b0;
	logic rx_enable = 1'b1;
	logic tx_empty_irq_enable = 1'b0;
	logic tx_finished_irq_enable = 1'b0;
	logic rx_full_irq_enable = 1'b1;
	logic line_quiet_irq_enable = 1'b0;
	logic tx_queued = 1'b0;
	logic hold = 1'b1;
	logic [8:0] rx_char_data = 9'h000;
	logic [5:0] evs = 6'h00;
	logic [2:0] errs = 3'h0;
	logic [7:0] bus_rdata;
	logic tx_space_ok, tx_valid, tx_ready, tx_busy, irq_tx, irq_rx, irq_err, took;
	logic [8:0] tx_data, took_word;
	wire rx_char_valid, rx_break, rx_line_quiet, rx_line_one, rx_start_zero, rx_false_start;
	wire rx_char_noise, rx_char_frame_err, rx_char_parity_err;
	logic [7:0] m_pri = 8'hC0, m_sec = 8'h00, m_cw = 8'h00, m_byte, m_arm = 8'h00;
	logic [7:0] m_sarm = 8'h00, b0, b1;
	logic m_n9, m_iok = 1'b0, m_lock = 1'b0;
	logic [15:0] seed = 16'h9AF8;
	logic [8:0] got_q[$];
	int n_fail = 0;
	int n_compared = 0;
	assign {rx_false_start, rx_start_zero, rx_line_one, rx_line_quiet, rx_break} = evs[5:1];
	assign rx_char_valid = evs[0];
	assign {rx_char_noise, rx_char_frame_err, rx_char_parity_err} = errs;
	always #2.5 clk_sys = ~clk_sys;
	eap_regs dut (.*);
	eap_tx_partner ptn (.clk_sys(clk_sys), .rst_n(rst_n), .hold(hold), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_ready(tx_ready), .tx_busy(tx_busy), .took(took),
		.took_word(took_word));
	always @(posedge clk_sys) if (took) got_q.push_back(took_word);
	// ----------------------------------------
	// Tasks and model
	// ----------------------------------------
	function automatic logic [15:0] lf(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic tally_and_finish;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wrr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge clk_sys);
		bus_wr <= 1'b0;
		if (a == 8'h15) m_cw = d & 8'h4F;
		if (a == 8'h18 && m_arm[7]) m_pri[7] = 1'b0;
		if (a == 8'h18) m_pri[6] = 1'b0;
	endtask
	task automatic acc(input logic [7:0] a);
		logic [7:0] e;
		case (a)
			8'h15: e = {m_n9, m_cw[6:0]};
			8'h16: e = m_pri;
			8'h17: e = m_sec;
			8'h18: e = m_byte;
			default: e = 8'h00;
		endcase
		@(posedge clk_sys);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge clk_sys);
		bus_rd <= 1'b0;
		#1 chk("bus_rdata", e, bus_rdata);
		if (a == 8'h16) m_arm = m_pri;
		if (a == 8'h17) m_sarm = m_sec;
		if (a == 8'h18) begin
			m_pri = m_pri & ~(m_arm & 8'h3F);
			m_sec = m_sec & ~(m_sarm & 8'h02);
			m_arm = 8'h00;
			m_sarm = 8'h00;
		end
	endtask
	// Event codes: 0 char, 1 break, 2 quiet line, 3 ones seen, 4 start zero, 5 false start
	task automatic ev(input int k, input logic [8:0] d, input logic [2:0] er);
		@(posedge clk_sys);
		evs <= 6'h01 << k;
		rx_char_data <= d;
		errs <= er;
		@(posedge clk_sys);
		evs <= 6'h00;
		case (k)
			0: if (m_pri[5]) m_pri[3] = 1'b1;
			else begin
				m_pri = m_pri | 8'h20 | er;
				m_byte = d[7:0];
				m_n9 = char_nine_bits ? d[8] : d[7];
				m_iok = 1'b1;
			end
			1: begin
				m_pri = m_pri | 8'h22;
				m_byte = 8'h00;
				m_n9 = 1'b0;
				if (!m_lock) m_sec[1] = 1'b1;
				m_lock = 1'b1;
			end
			2: begin
				if (m_iok) m_pri[4] = 1'b1;
				m_iok = 1'b0;
				m_sec[0] = 1'b0;
			end
			3: m_lock = 1'b0;
			4: m_sec[0] = 1'b1;
			default: m_sec[0] = 1'b0;
		endcase
		repeat (3) @(posedge clk_sys);
		#1;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		#50000;
		n_fail++;
		tally_and_finish();
	end
	initial begin
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		acc(8'h16);
		acc(8'h17);
		acc(8'h20);
		wrr(8'h16, 8'hFF);
		acc(8'h16);
		ev(0, 9'h1C3, 3'h0);
		acc(8'h15);
		acc(8'h16);
		acc(8'h18);
		seed = lf(seed);
		wrr(8'h15, seed[7:0]);
		acc(8'h15);
		for (int k = 0; k < 4; k++) begin
			char_nine_bits <= k[0];
			wrr(8'h15, 8'h0F ^ (8'h01 << k));
			seed = lf(seed);
			ev(0, seed[8:0], 3'b001 << k);
			if (k == 3) ev(0, seed[15:7], 3'h0);
			chk("irq_err", 1'b0, irq_err);
			chk("irq_rx", 1'b1, irq_rx);
			acc(8'h15);
			wrr(8'h15, 8'h01 << k);
			repeat (3) @(posedge clk_sys);
			#1 chk("irq_err", 1'b1, irq_err);
			acc(8'h16);
			acc(8'h18);
			acc(8'h16);
		end
		ev(0, 9'h0A5, 3'h0);
		acc(8'h16);
		ev(0, 9'h05A, 3'h0);
		acc(8'h18);
		acc(8'h16);
		acc(8'h18);
		acc(8'h16);
		rx_full_irq_enable <= 1'b0;
		line_quiet_irq_enable <= 1'b1;
		rx_enable <= 1'b0;
		@(posedge clk_sys);
		rx_enable <= 1'b1;
		m_iok = 1'b0;
		ev(2, 9'h000, 3'h0);
		acc(8'h16);
		ev(0, 9'h033, 3'h0);
		acc(8'h16);
		acc(8'h18);
		ev(2, 9'h000, 3'h0);
		chk("irq_rx", 1'b1, irq_rx);
		acc(8'h16);
		acc(8'h18);
		ev(2, 9'h000, 3'h0);
		acc(8'h16);
		ev(4, 9'h000, 3'h0);
		acc(8'h17);
		ev(5, 9'h000, 3'h0);
		acc(8'h17);
		ev(4, 9'h000, 3'h0);
		ev(2, 9'h000, 3'h0);
		acc(8'h17);
		line_quiet_irq_enable <= 1'b0;
		wrr(8'h15, 8'h00);
		char_nine_bits <= 1'b1;
		for (int j = 0; j < 3; j++) begin
			if (j != 1) ev(3, 9'h000, 3'h0);
			ev(1, 9'h000, 3'h0);
			chk("irq_err", 1'b0, irq_err);
			acc(8'h15);
			acc(8'h17);
			acc(8'h16);
			acc(8'h18);
			acc(8'h17);
		end
		wrr(8'h15, 8'h40);
		tx_empty_irq_enable <= 1'b1;
		@(posedge clk_sys);
		#1 chk("irq_tx", 1'b1, irq_tx);
		acc(8'h16);
		seed = lf(seed);
		b0 = seed[7:0];
		wrr(8'h18, b0);
		seed = lf(seed);
		b1 = seed[7:0];
		wrr(8'h18, b1);
		repeat (3) @(posedge clk_sys);
		#1 chk("tx_space_ok", 1'b0, tx_space_ok);
		chk("irq_tx", 1'b0, irq_tx);
		acc(8'h16);
		acc(8'h18);
		wrr(8'h18, 8'hFF);
		hold <= 1'b0;
		tx_finished_irq_enable <= 1'b1;
		repeat (40) @(posedge clk_sys);
		m_pri[7:6] = 2'b11;
		acc(8'h16);
		chk("irq_tx", 1'b1, irq_tx);
		chk("words", 9'd2, got_q.size());
		chk("word0", {1'b1, b0}, got_q[0]);
		chk("word1", {1'b1, b1}, got_q[1]);
		tx_queued <= 1'b1;
		m_pri[6] = 1'b0;
		acc(8'h16);
		tx_queued <= 1'b0;
		m_pri[6] = 1'b1;
		hold <= 1'b1;
		acc(8'h16);
		wrr(8'h18, 8'h11);
		port_enable <= 1'b0;
		repeat (3) @(posedge clk_sys);
		m_pri[7:6] = 2'b11;
		acc(8'h16);
		chk("irq_tx", 1'b0, irq_tx);
		ev(0, 9'h1B7, 3'h0);
		rst_n <= 1'b0;
		port_enable <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		m_pri = 8'hC0;
		m_sec = 8'h00;
		m_cw = 8'h00;
		acc(8'h18);
		acc(8'h15);
		tally_and_finish();
	end
endmodule // test_eap_regs
`default_nettype wire
